// *** src/ssb_serial_status_bitrate.sv ***
// serial status flags, bit-rate register and bit-rate generator
//
// What this block does
// [R1] async reception end: stop bit 0 sets the framing error flag
// [R2] with two stop bits only the first stop bit is checked
// [R3] framing error: character stored, buffer-full left clear, reception halted
// [R4] error flags clear only by writing 0 after reading them as 1, or on reset and low-power entry
// [R5] clearing receive enable leaves the error flags unchanged
// [R6] async parity enabled: ones count mismatch sets the parity error flag
// [R7] parity error: character stored, buffer-full left clear, reception halted
// [R8] sync mode: a set receive error flag also halts transmission
// [R9] transmit-end flag is read-only, software writes ignored
// [R10] transmit-end sets while transmit disabled or buffer empty at last bit
// [R11] transmit-end clears on buffer-empty clear or controller holding write
// [R12] async multiprocessor format stores received multiprocessor bit, read-only
// [R13] received multiprocessor bit kept when receive enable clears
// [R14] async multiprocessor transmit appends the software transmit multiprocessor bit
// [R15] transmit multiprocessor bit ignored outside async multiprocessor transmission
// [R16] bit rate from 8-bit value on prescaler-selected generator clock
// [R17] bit-rate register readable and writable at any time
// [R18] bit-rate register all ones on reset and low-power entry
// [R19] this channel has its own generator and rate setting
// [R20] buffer-full sets only on error-free reception into the holding register
// [R21] writes of 1 to the writable flags are ignored, except by the transmit multiprocessor bit
// [R22] clearing write works only after a read as 1; newer sets survive
`timescale 1ns/1ps

module ssb_serial_status_bitrate (
    input wire logic clk,
    input wire logic rstn,
    input wire logic lowPowerStop,
    input wire logic [ssb_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ssb_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire ssb_pkg::ssb_rx_frame_t rxFrame,
    input wire logic xferRxRead,
    input wire logic txLoad,
    input wire logic txLastBit,
    input wire logic xferTxWrite,
    output ssb_pkg::ssb_cfg_t serialControl,
    output ssb_pkg::ssb_flags_t serialFlags,
    output logic [7:0] rxHolding,
    output logic rxHalt,
    output logic txHalt,
    output logic txMpAppend,
    output logic txMpValue,
    output logic rateTick
);

    ssb_pkg::ssb_state_t st;
    ssb_pkg::ssb_state_t next_st;

    logic doWrite;
    logic doRead;
    logic errorHeld;
    logic framingBad;
    logic parityBad;
    logic rxAccept;

    // one address decode shared by the write and read paths
    typedef enum {
        SSB_SEL_FLAGS,
        SSB_SEL_RATE,
        SSB_SEL_CONFIG,
        SSB_SEL_HOLDING,
        SSB_SEL_NONE
    } ssb_sel_t;

    function automatic ssb_sel_t ssb_decode(input logic [ssb_pkg::ADDR_W-1:0] addr);
        ssb_sel_t sel;
        case (addr)
            ssb_pkg::ADDR_FLAGS: begin
                sel = SSB_SEL_FLAGS;
            end
            ssb_pkg::ADDR_RATE: begin
                sel = SSB_SEL_RATE;
            end
            ssb_pkg::ADDR_CONFIG: begin
                sel = SSB_SEL_CONFIG;
            end
            ssb_pkg::ADDR_RX_HOLDING: begin
                sel = SSB_SEL_HOLDING;
            end
            default: begin
                sel = SSB_SEL_NONE;
            end
        endcase
        return sel;
    endfunction

    // a zero written over a flag that was read as one
    function automatic logic ssb_clear_ok(input logic written, input logic armed);
        return ~written & armed;
    endfunction

    ssb_sel_t wrSel;
    ssb_sel_t rdSel;

    // either receive error flag freezes the receiver
    assign errorHeld = st.flags.framingErrorFlag | st.flags.parityErrorFlag;
    assign rxHalt = errorHeld; // [R3] [R7]
    assign txHalt = errorHeld & st.cfg.syncMode; // [R8]
    // shifter only looks at this while a character is being sent
    assign txMpAppend = st.cfg.multiproc & ~st.cfg.syncMode; // [R15]
    assign txMpValue = st.flags.txMultiprocBit & txMpAppend; // [R14] [R15]

    // second stop bit deliberately never examined
    assign framingBad = ~st.cfg.syncMode & ~rxFrame.stopBit; // [R1] [R2]
    assign parityBad = ~st.cfg.syncMode & st.cfg.parityEnable
        & ((^rxFrame.data ^ rxFrame.parityBit) != st.cfg.parityOdd); // [R6]
    // a full buffer drops the character: the earlier one is kept
    assign rxAccept = rxFrame.done & st.cfg.rxEnable & ~errorHeld & ~st.flags.rxBufferFull;

    assign doWrite = st.awHeld & st.wHeld & ~st.bValid;
    assign doRead = s_axi_arvalid & ~st.rValid;
    assign wrSel = ssb_decode(st.awAddr);
    assign rdSel = ssb_decode(s_axi_araddr);

    assign s_axi_awready = ~st.awHeld;
    assign s_axi_wready = ~st.wHeld;
    assign s_axi_arready = ~st.rValid;
    assign s_axi_bvalid = st.bValid;
    assign s_axi_bresp = st.bResp;
    assign s_axi_rvalid = st.rValid;
    assign s_axi_rdata = st.rData;
    assign s_axi_rresp = st.rResp;

    assign serialControl = st.cfg;
    assign serialFlags = st.flags;
    assign rxHolding = st.rxHolding;
    assign rateTick = st.rateTick;

    always_comb begin
        ssb_pkg::ssb_flags_t wf;
        logic [5:0] prescLimit;
        next_st = st;
        wf = ssb_pkg::ssb_flags_t'(st.wData[7:0]);
        prescLimit = ssb_pkg::PRESC_LIMIT[st.cfg.prescalerSelect];
        next_st.rateTick = 1'b0;

        // bus channel capture and release
        if (s_axi_awvalid && !st.awHeld) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.wHeld) begin
            next_st.wHeld = 1'b1;
            next_st.wData = s_axi_wdata[8:0];
            next_st.wStrb = s_axi_wstrb[1:0];
        end
        if (st.bValid && s_axi_bready) begin
            next_st.bValid = 1'b0;
        end
        if (st.rValid && s_axi_rready) begin
            next_st.rValid = 1'b0;
        end

        // register writes; clears come before hardware sets so sets win
        if (doWrite) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp = ssb_pkg::RESP_OKAY;
            case (wrSel)
                SSB_SEL_FLAGS: begin
                    if (st.wStrb[0]) begin
                        // ones are ignored except by the transmit multiprocessor bit; transmit-end clears only with buffer-empty, receive bit untouched
                        if (ssb_clear_ok(wf.txBufferEmpty, st.seen.txBufferEmpty)) begin // [R21] [R22]
                            next_st.flags.txBufferEmpty = 1'b0;
                            next_st.flags.transmitEndFlag = 1'b0; // [R11]
                        end
                        if (ssb_clear_ok(wf.rxBufferFull, st.seen.rxBufferFull)) begin // [R21] [R22]
                            next_st.flags.rxBufferFull = 1'b0;
                        end
                        if (ssb_clear_ok(wf.framingErrorFlag, st.seen.framingErrorFlag)) begin // [R4]
                            next_st.flags.framingErrorFlag = 1'b0;
                        end
                        if (ssb_clear_ok(wf.parityErrorFlag, st.seen.parityErrorFlag)) begin // [R4]
                            next_st.flags.parityErrorFlag = 1'b0;
                        end
                        next_st.flags.txMultiprocBit = wf.txMultiprocBit; // [R14]
                        next_st.seen = ssb_pkg::ssb_flags_t'(8'h00); // [R9] [R12]
                    end
                end
                SSB_SEL_RATE: begin
                    if (st.wStrb[0]) begin
                        next_st.bitRateValue = st.wData[7:0]; // [R17]
                        next_st.prescCount = 6'h00;
                        next_st.rateCount = st.wData[7:0];
                    end
                end
                SSB_SEL_CONFIG: begin
                    if (st.wStrb[0]) begin
                        next_st.cfg[7:0] = st.wData[7:0];
                    end
                    if (st.wStrb[1]) begin
                        next_st.cfg[ssb_pkg::CONFIG_HIGH_BIT] =
                            st.wData[ssb_pkg::CONFIG_HIGH_BIT];
                    end
                end
                SSB_SEL_HOLDING: begin
                end
                default: begin
                    next_st.bResp = ssb_pkg::RESP_SLVERR;
                end
            endcase
        end

        // register reads; reading a flag as 1 arms its clear
        if (doRead) begin
            next_st.rValid = 1'b1;
            next_st.rResp = ssb_pkg::RESP_OKAY;
            next_st.rData = 32'h0000_0000;
            case (rdSel)
                SSB_SEL_FLAGS: begin
                    next_st.rData[7:0] = st.flags;
                    next_st.seen = next_st.seen | st.flags; // [R4] [R22]
                end
                SSB_SEL_RATE: begin
                    next_st.rData[7:0] = st.bitRateValue; // [R17]
                end
                SSB_SEL_CONFIG: begin
                    next_st.rData[8:0] = st.cfg;
                end
                SSB_SEL_HOLDING: begin
                    next_st.rData[7:0] = st.rxHolding;
                end
                default: begin
                    next_st.rResp = ssb_pkg::RESP_SLVERR;
                end
            endcase
        end

        // other-party clears
        if (xferRxRead) begin
            next_st.flags.rxBufferFull = 1'b0;
        end
        if (xferTxWrite) begin
            next_st.flags.txBufferEmpty = 1'b0;
            next_st.flags.transmitEndFlag = 1'b0; // [R11]
        end

        // receive completion; receive enable never touches error flags
        if (rxAccept) begin // [R5] [R13]
            next_st.rxHolding = rxFrame.data; // [R3] [R7]
            if (framingBad) begin
                next_st.flags.framingErrorFlag = 1'b1; // [R1]
            end
            if (parityBad) begin
                next_st.flags.parityErrorFlag = 1'b1; // [R6]
            end
            if (!framingBad && !parityBad) begin
                next_st.flags.rxBufferFull = 1'b1; // [R20]
            end
            if (st.cfg.multiproc && !st.cfg.syncMode) begin
                next_st.flags.rxMultiprocBit = rxFrame.mpBit; // [R12]
            end
        end

        // transmit side sets
        if (txLoad) begin
            next_st.flags.txBufferEmpty = 1'b1;
        end
        if (txLastBit && st.flags.txBufferEmpty) begin
            next_st.flags.transmitEndFlag = 1'b1; // [R10]
        end
        if (!st.cfg.txEnableBit) begin
            next_st.flags.txBufferEmpty = 1'b1;
            next_st.flags.transmitEndFlag = 1'b1; // [R10]
        end

        // a flag that went low by any path loses its earlier read
        next_st.seen = next_st.seen & next_st.flags; // [R22]

        // bit-rate generator, private to this channel
        if (st.prescCount == prescLimit) begin // [R16] [R19]
            next_st.prescCount = 6'h00;
            if (st.rateCount == 8'h00) begin
                next_st.rateCount = st.bitRateValue; // [R16]
                next_st.rateTick = 1'b1;
            end else begin
                next_st.rateCount = st.rateCount - 8'h01;
            end
        end else begin
            next_st.prescCount = st.prescCount + 6'h01;
        end

        // low-power entry reloads the unit's registers, except the receive holding register
        if (lowPowerStop) begin
            next_st.flags = ssb_pkg::ssb_flags_t'(ssb_pkg::FLAGS_RESET);
            next_st.seen = ssb_pkg::ssb_flags_t'(8'h00);
            next_st.bitRateValue = ssb_pkg::RATE_RESET; // [R18]
            next_st.rateCount = ssb_pkg::RATE_RESET;
            next_st.prescCount = 6'h00;
            next_st.rateTick = 1'b0;
            next_st.cfg = ssb_pkg::ssb_cfg_t'(ssb_pkg::CONFIG_RESET);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st.flags <= ssb_pkg::ssb_flags_t'(ssb_pkg::FLAGS_RESET);
            st.seen <= ssb_pkg::ssb_flags_t'(8'h00);
            st.bitRateValue <= ssb_pkg::RATE_RESET; // [R18]
            st.cfg <= ssb_pkg::ssb_cfg_t'(ssb_pkg::CONFIG_RESET);
            st.rxHolding <= ssb_pkg::RX_HOLDING_RESET;
            st.prescCount <= 6'h00;
            st.rateCount <= ssb_pkg::RATE_RESET;
            st.rateTick <= 1'b0;
            st.awHeld <= 1'b0;
            st.awAddr <= '0;
            st.wHeld <= 1'b0;
            st.wData <= 9'h000;
            st.wStrb <= 2'h0;
            st.bValid <= 1'b0;
            st.bResp <= ssb_pkg::RESP_OKAY;
            st.rValid <= 1'b0;
            st.rData <= 32'h0000_0000;
            st.rResp <= ssb_pkg::RESP_OKAY;
        end else begin
            st <= next_st;
        end
    end

endmodule // ssb_serial_status_bitrate

// *** src/ssb_pkg.sv ***
// constants and types for the serial status and bit-rate block
package ssb_pkg;

    localparam int ADDR_W = 8;

    // byte addresses on the register bus
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RATE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_RX_HOLDING = 8'h0C;

    // values after reset; all but the holding value also after low-power entry
    localparam logic [7:0] FLAGS_RESET = 8'h84;
    localparam logic [7:0] RATE_RESET = 8'hFF;
    localparam logic [8:0] CONFIG_RESET = 9'h000;
    localparam logic [7:0] RX_HOLDING_RESET = 8'h00;

    // position of the top configuration bit, written through byte lane 1
    localparam int CONFIG_HIGH_BIT = 8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // prescaler terminal counts: divide by 1, 4, 16, 64
    localparam logic [3:0][5:0] PRESC_LIMIT = {6'h3F, 6'h0F, 6'h03, 6'h00};

    // bit 7 down to bit 0 of the serial_flags register
    typedef struct packed {
        logic txBufferEmpty;
        logic rxBufferFull;
        logic overrun;
        logic framingErrorFlag;
        logic parityErrorFlag;
        logic transmitEndFlag;
        logic rxMultiprocBit;
        logic txMultiprocBit;
    } ssb_flags_t;

    // bit 8 down to bit 0 of the configuration register
    typedef struct packed {
        logic [1:0] prescalerSelect;
        logic multiproc;
        logic twoStop;
        logic parityOdd;
        logic parityEnable;
        logic syncMode;
        logic txEnableBit;
        logic rxEnable;
    } ssb_cfg_t;

    // one finished character from the receive shifter
    typedef struct packed {
        logic done;
        logic [7:0] data;
        logic parityBit;
        logic stopBit;
        logic secondStopBit;
        logic mpBit;
    } ssb_rx_frame_t;

    typedef struct packed {
        ssb_flags_t flags;
        ssb_flags_t seen;
        logic [7:0] bitRateValue;
        ssb_cfg_t cfg;
        logic [7:0] rxHolding;
        logic [5:0] prescCount;
        logic [7:0] rateCount;
        logic rateTick;
        logic awHeld;
        logic [ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [8:0] wData;
        logic [1:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } ssb_state_t;

endpackage

// *** tb/ssb_sva.sv ***
// assertion checker for the serial status and bit-rate block
`timescale 1ns/1ps
module ssb_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire logic lowPowerStop,
    input wire ssb_pkg::ssb_rx_frame_t rxFrame,
    input wire ssb_pkg::ssb_cfg_t serialControl,
    input wire ssb_pkg::ssb_flags_t serialFlags,
    input wire logic [7:0] rxHolding,
    input wire logic rxHalt,
    input wire logic txHalt,
    input wire logic txMpValue
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // a character the block is willing to take
    sequence s_acc;
        rxFrame.done && serialControl.rxEnable && !rxHalt && !serialFlags.rxBufferFull
            && !lowPowerStop && !serialControl.syncMode;
    endsequence
    sequence s_bad_par;
        serialControl.parityEnable
            && ((^rxFrame.data ^ rxFrame.parityBit) != serialControl.parityOdd);
    endsequence
    a_framing_sets:
    assert property (s_acc ##0 !rxFrame.stopBit |=> serialFlags.framingErrorFlag
        && !serialFlags.rxBufferFull && rxHolding == $past(rxFrame.data))
        else $error("framing error not flagged");
    a_parity_sets:
    assert property (s_acc ##0 s_bad_par |=> serialFlags.parityErrorFlag
        && !serialFlags.rxBufferFull && rxHolding == $past(rxFrame.data))
        else $error("parity error not flagged");
    a_mp_capture:
    assert property (s_acc ##0 serialControl.multiproc
        |=> serialFlags.rxMultiprocBit == $past(rxFrame.mpBit))
        else $error("received multiprocessor bit not stored");
    a_refused_hold:
    assert property (rxHalt && rxFrame.done && !lowPowerStop |=> $stable(rxHolding))
        else $error("character taken while halted");
    a_halt_level:
    assert property (rxHalt == (serialFlags.framingErrorFlag || serialFlags.parityErrorFlag))
        else $error("receive halt does not follow error flags");
    a_sync_halt:
    assert property (txHalt == (rxHalt && serialControl.syncMode))
        else $error("transmit halt wrong");
    a_mp_gate:
    assert property (txMpValue == (serialFlags.txMultiprocBit && serialControl.multiproc
        && !serialControl.syncMode))
        else $error("transmit multiprocessor bit gating wrong");
    a_transmit_end_flag_forced:
    assert property (!serialControl.txEnableBit |=> serialFlags.transmitEndFlag)
        else $error("transmit end not forced while disabled");
    a_lp_reload:
    assert property (lowPowerStop
        |=> serialFlags == ssb_pkg::ssb_flags_t'(ssb_pkg::FLAGS_RESET))
        else $error("flags not reloaded on low-power entry");
endmodule // ssb_sva

bind ssb_serial_status_bitrate ssb_sva chk_u (.clk(clk), .rstn(rstn),
    .lowPowerStop(lowPowerStop), .rxFrame(rxFrame), .serialControl(serialControl),
    .serialFlags(serialFlags), .rxHolding(rxHolding), .rxHalt(rxHalt), .txHalt(txHalt),
    .txMpValue(txMpValue));

// *** tb/ssb_far_model.sv ***
// far-end transceiver model: hands finished characters to the block
`timescale 1ns/1ps
module ssb_far_model (
    input wire logic clk,
    output ssb_pkg::ssb_rx_frame_t rxFrame
);
    initial rxFrame = '0;
    // fields inverted after the pulse so stale values never look valid
    task automatic send(input logic [7:0] d, input logic p, input logic s, input logic s2,
        input logic mp);
        rxFrame <= {1'b1, d, p, s, s2, mp};
        @(posedge clk);
        rxFrame <= {1'b0, ~d, ~p, ~s, ~s2, ~mp};
        @(posedge clk);
    endtask
endmodule // ssb_far_model

// *** tb/ssb_serial_status_bitrate_tb.sv ***
// self-checking bench for the serial status and bit-rate block
`timescale 1ns/1ps
module ssb_serial_status_bitrate_tb;
    localparam logic [7:0] AF = ssb_pkg::ADDR_FLAGS;
    localparam logic [7:0] AR = ssb_pkg::ADDR_RATE;
    localparam logic [7:0] AC = ssb_pkg::ADDR_CONFIG;
    localparam logic [7:0] AH = ssb_pkg::ADDR_RX_HOLDING;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic lowPowerStop = 1'b0;
    logic [7:0] awAddr = 8'h00;
    logic awValid = 1'b0;
    logic [31:0] wData = 32'h0;
    logic wValid = 1'b0;
    logic [7:0] arAddr = 8'h00;
    logic arValid = 1'b0;
    logic [3:0] txp = 4'h0;
    logic awReady, wReady, bValid, arReady, rValid;
    logic rxHalt, txHalt, txMpAppend, txMpValue, rateTick;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    logic [7:0] rxHolding;
    ssb_pkg::ssb_rx_frame_t rxFrame;
    ssb_pkg::ssb_cfg_t serialControl;
    ssb_pkg::ssb_flags_t serialFlags;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    integer seed = 46;
    logic [7:0] rv;
    always #10 clk = ~clk;
    ssb_far_model far_u (.clk(clk), .rxFrame(rxFrame));
    ssb_serial_status_bitrate dut_u (.clk(clk), .rstn(rstn), .lowPowerStop(lowPowerStop),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'h3), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(1'b1),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'b1),
        .rxFrame(rxFrame), .xferRxRead(txp[3]), .txLoad(txp[2]), .txLastBit(txp[1]),
        .xferTxWrite(txp[0]), .serialControl(serialControl), .serialFlags(serialFlags),
        .rxHolding(rxHolding), .rxHalt(rxHalt), .txHalt(txHalt), .txMpAppend(txMpAppend),
        .txMpValue(txMpValue), .rateTick(rateTick));
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %0t got %h expected %h", $time, g, e);
            fails++;
        end
    endtask
    task automatic stop_test();
        if (rq.size() != 0 || bq.size() != 0) begin
            $display("[ERR] %0t bus answers missing", $time);
            fails++;
        end
        if (fails == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bq.push_back(r);
        do begin
            @(posedge clk);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end while ((awValid && !awReady) || (wValid && !wReady));
        do @(posedge clk); while (!bValid);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = 2'h0);
        arAddr <= a;
        arValid <= 1'b1;
        rq.push_back({r, 24'h0, e});
        do @(posedge clk); while (!arReady);
        arValid <= 1'b0;
        do @(posedge clk); while (!rValid);
    endtask
    // one-cycle pulse on controller read, load, last bit or controller write
    task automatic tp(input logic [3:0] v);
        txp <= v;
        @(posedge clk);
        txp <= 4'h0;
        @(posedge clk);
    endtask
    // watcher: answers are matched to the oldest note
    always @(posedge clk) begin
        cyc++;
        if (rValid) begin
            if (rq.size() == 0) begin
                $display("[ERR] %0t read answer without request", $time);
                fails++;
            end else begin
                chk({rResp, rData}, rq.pop_front());
            end
        end
        if (bValid) begin
            if (bq.size() == 0) begin
                $display("[ERR] %0t write answer without request", $time);
                fails++;
            end else begin
                chk(34'(bResp), 34'(bq.pop_front()));
            end
        end
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(AF, 8'h84);
        rd(AR, 8'hFF);
        rd(8'h10, 8'h00, ssb_pkg::RESP_SLVERR);
        wr(8'h10, 32'h0, ssb_pkg::RESP_SLVERR);
        rv = 8'($random(seed));
        wr(AR, {24'h0, rv});
        rd(AR, rv);
        wr(AR, 32'h3);
        wr(AC, 32'hEB);
        // first loop finds a tick, second measures the period
        repeat (2) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (!rateTick && n < 999);
        end
        chk(34'(n), 34'd16);
        far_u.send(8'hA5, 1'b0, 1'b1, 1'b0, 1'b1);
        rd(AF, 8'hC6);
        rd(AH, 8'hA5);
        wr(AF, 32'hBF);
        rd(AF, 8'h87);
        chk(34'(txMpValue), 34'h1);
        far_u.send(8'h3C, 1'b0, 1'b0, 1'b1, 1'b1);
        far_u.send(8'h11, 1'b0, 1'b1, 1'b0, 1'b0);
        chk(34'({rxHalt, rxHolding}), 34'h13C);
        rd(AH, 8'h3C);
        wr(AC, 32'hEA);
        rd(AF, 8'h97);
        wr(AF, 32'hFF);
        wr(AF, 32'hEF);
        rd(AF, 8'h97);
        wr(AF, 32'hEF);
        rd(AF, 8'h87);
        wr(AC, 32'hEB);
        // one data bit plus a zero parity bit is odd: wrong under even parity
        far_u.send(8'h01, 1'b0, 1'b1, 1'b1, 1'b0);
        rd(AF, 8'h8D);
        rd(AH, 8'h01);
        wr(AC, 32'hEF);
        chk(34'({txHalt, txMpAppend}), 34'h2);
        wr(AC, 32'hEB);
        wr(AF, 32'hF3);
        rd(AF, 8'h85);
        wr(AF, 32'h7F);
        rd(AF, 8'h01);
        tp(4'h2);
        rd(AF, 8'h01);
        tp(4'h4);
        tp(4'h2);
        rd(AF, 8'h85);
        tp(4'h1);
        rd(AF, 8'h01);
        wr(AC, 32'hE9);
        rd(AF, 8'h85);
        far_u.send(8'h5A, 1'b0, 1'b1, 1'b1, 1'b0);
        rd(AF, 8'hC5);
        tp(4'h8);
        rd(AF, 8'h85);
        lowPowerStop <= 1'b1;
        @(posedge clk);
        lowPowerStop <= 1'b0;
        rd(AR, 8'hFF);
        rd(AF, 8'h84);
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule // ssb_serial_status_bitrate_tb
